/* File: core/iepr_src_cell.sv */
// One interrupt source: request gating and level forming
`timescale 1ns/10ps
`default_nettype none
module iepr_src_cell (
   // Source state
   input  wire logic       pending,
   input  wire logic       own_gate,
   input  wire logic       global_gate,
   // Priority bits
   input  wire logic       prio_hi,
   input  wire logic       prio_lo,
   // Gated result
   output logic            req,
   output logic [1:0]      level
);
   // Pass only with flag, own gate and master gate all set
   assign req   = pending & own_gate & global_gate;
   // High bit is the MSB of the level
   assign level = {prio_hi, prio_lo};
endmodule
`default_nettype wire

/* File: core/iepr_top.sv */
// Interrupt enable and priority register bank with AXI4-Lite access
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Master gate bit 7 of first enable blocks all sources while clear.
// - First enable bit 4 passes or blocks the serial request.
// - First enable bit 3 passes or blocks the timer one overflow.
// - First enable bit 2 passes or blocks external request one.
// - First enable bit 1 passes or blocks the timer zero overflow.
// - First enable bit 0 passes or blocks external request zero.
// - First enable register resets to zero; bits 6 and 5 reserved.
// - Second enable bit 6 gates the USB request.
// - Second enable bit 3 gates the smart card request.
// - Second enable bit 2 gates the SPI request on full variant.
// - Second enable bit 0 gates the keypad request on full variant.
// - Full variant second enable resets defined bits to zero; others reserved.
// - Reduced variant keeps only bits 6 and 3, both reset to zero.
// - Low priority register holds one bit for each of sources 0 to 4, bits 4 to 0.
// - Low priority register resets its five bits to zero.
// - High priority register holds partner bits at the same positions.
// - Level is high bit as MSB, low bit as LSB, 0 to 3.
// - Only a strictly higher level preempts; top level never preempted.
// - Equal levels are settled by a fixed polling order.
module iepr_top #(
   parameter bit FULL_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // Write data channel
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // Write response channel
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read address channel
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // Read data channel
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Source flags and running handler
   input  wire logic [8:0]  irq_pending,
   input  wire logic        in_service_valid,
   input  wire logic [1:0]  in_service_level,
   // Gated requests and levels
   output logic [8:0]       irq_gated,
   output logic [17:0]      irq_level,
   // Arbitration result
   output logic             win_valid,
   output logic [3:0]       win_index,
   output logic [1:0]       win_level
);
   localparam logic [7:0] EN_SECOND_MASK = FULL_VARIANT ? iepr_pkg::IEPR_EN_SECOND_FULL
                                                        : iepr_pkg::IEPR_EN_SECOND_SMALL;

   logic [7:0]  en_first;
   logic [7:0]  en_second;
   logic [7:0]  prio_lo;
   logic [7:0]  prio_hi;
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr_q;
   logic [7:0]  w_byte_q;
   logic        w_strb_q;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        wr_hit;
   logic [8:0]  src_gate;
   logic [8:0]  src_hi;
   logic [8:0]  src_lo;
   logic [8:0]  cell_req;
   logic [17:0] cell_level;
   logic        next_win_valid;
   logic [3:0]  next_win_index;
   logic [1:0]  next_win_level;
   logic        do_write;

   assign do_write = aw_held && w_held && !bvalid;

   // Write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= 12'h000;
         w_byte_q  <= 8'h00;
         w_strb_q  <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_held   <= 1'b1;
            awready   <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_held   <= 1'b1;
            wready   <= 1'b0;
            w_byte_q <= wdata[7:0];
            w_strb_q <= wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
         if (bvalid && bready) begin
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Write address decode
   always_comb begin
      case (aw_addr_q)
         iepr_pkg::IEPR_EN_FIRST_ADDR:  wr_hit = 1'b1;
         iepr_pkg::IEPR_EN_SECOND_ADDR: wr_hit = 1'b1;
         iepr_pkg::IEPR_PRIO_HI_ADDR:   wr_hit = 1'b1;
         iepr_pkg::IEPR_PRIO_LO_ADDR:   wr_hit = 1'b1;
         default:                       wr_hit = 1'b0;
      endcase
   end

   // Write response, error on unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= iepr_pkg::IEPR_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? iepr_pkg::IEPR_RESP_OKAY : iepr_pkg::IEPR_RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Register storage, reserved bits held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_first  <= iepr_pkg::IEPR_REG_RESET;
         en_second <= iepr_pkg::IEPR_REG_RESET;
         prio_lo   <= iepr_pkg::IEPR_REG_RESET;
         prio_hi   <= iepr_pkg::IEPR_REG_RESET;
      end else if (do_write && w_strb_q) begin
         case (aw_addr_q)
            iepr_pkg::IEPR_EN_FIRST_ADDR:
               en_first <= w_byte_q & iepr_pkg::IEPR_EN_FIRST_MASK;
            iepr_pkg::IEPR_EN_SECOND_ADDR:
               en_second <= w_byte_q & EN_SECOND_MASK;
            iepr_pkg::IEPR_PRIO_HI_ADDR:
               prio_hi <= w_byte_q & iepr_pkg::IEPR_PRIO_MASK;
            iepr_pkg::IEPR_PRIO_LO_ADDR:
               prio_lo <= w_byte_q & iepr_pkg::IEPR_PRIO_MASK;
            default: ;
         endcase
      end
   end

   // Read mux, reserved and upper bits read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = iepr_pkg::IEPR_RESP_OKAY;
      case (araddr)
         iepr_pkg::IEPR_EN_FIRST_ADDR:  next_rdata[7:0] = en_first;
         iepr_pkg::IEPR_EN_SECOND_ADDR: next_rdata[7:0] = en_second;
         iepr_pkg::IEPR_PRIO_HI_ADDR:   next_rdata[7:0] = prio_hi;
         iepr_pkg::IEPR_PRIO_LO_ADDR:   next_rdata[7:0] = prio_lo;
         default:                       next_rresp = iepr_pkg::IEPR_RESP_SLVERR;
      endcase
   end

   // Read channel, one read under way at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= iepr_pkg::IEPR_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Per-source gate and priority bits
   always_comb begin
      src_gate = 9'h000;
      src_hi   = 9'h000;
      src_lo   = 9'h000;
      src_gate[iepr_pkg::IEPR_SRC_EXT_ZERO]   = en_first[iepr_pkg::IEPR_EXT_ZERO_BIT];
      src_gate[iepr_pkg::IEPR_SRC_TIMER_ZERO] = en_first[iepr_pkg::IEPR_TIMER_ZERO_BIT];
      src_gate[iepr_pkg::IEPR_SRC_EXT_ONE]    = en_first[iepr_pkg::IEPR_EXT_ONE_BIT];
      src_gate[iepr_pkg::IEPR_SRC_TIMER_ONE]  = en_first[iepr_pkg::IEPR_TIMER_ONE_BIT];
      src_gate[iepr_pkg::IEPR_SRC_SERIAL]     = en_first[iepr_pkg::IEPR_SERIAL_BIT];
      src_gate[iepr_pkg::IEPR_SRC_SPI]        = en_second[iepr_pkg::IEPR_SPI_BIT];
      src_gate[iepr_pkg::IEPR_SRC_KEYPAD]     = en_second[iepr_pkg::IEPR_KEYPAD_BIT];
      src_gate[iepr_pkg::IEPR_SRC_USB]        = en_second[iepr_pkg::IEPR_USB_BIT];
      src_gate[iepr_pkg::IEPR_SRC_CARD]       = en_second[iepr_pkg::IEPR_CARD_BIT];
      // First five sources share bit positions with the priority registers
      src_hi[4:0] = prio_hi[4:0];
      src_lo[4:0] = prio_lo[4:0];
   end

   // One gating cell per source
   genvar g;
   generate
      for (g = 0; g < iepr_pkg::IEPR_NUM_SRC; g++) begin : gen_src
         iepr_src_cell u_cell (
            .pending     (irq_pending[g]),
            .own_gate    (src_gate[g]),
            .global_gate (en_first[iepr_pkg::IEPR_GLOBAL_BIT]),
            .prio_hi     (src_hi[g]),
            .prio_lo     (src_lo[g]),
            .req         (cell_req[g]),
            .level       (cell_level[2*g+1:2*g])
         );
      end
   endgenerate

   // Pick highest level, lowest source number on a tie
   always_comb begin
      next_win_valid = 1'b0;
      next_win_index = 4'h0;
      next_win_level = iepr_pkg::IEPR_LEVEL_NONE;
      for (int i = iepr_pkg::IEPR_NUM_SRC - 1; i >= 0; i--) begin
         if (cell_req[i] && (!next_win_valid || cell_level[2*i+:2] >= next_win_level)) begin
            next_win_valid = 1'b1;
            next_win_index = 4'(i);
            next_win_level = cell_level[2*i+:2];
         end
      end
      // Running handler yields only to a strictly higher level
      if (in_service_valid && !(next_win_level > in_service_level)) begin
         next_win_valid = 1'b0;
      end
   end

   // Registered outputs toward the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_gated <= 9'h000;
         irq_level <= 18'h00000;
         win_valid <= 1'b0;
         win_index <= 4'h0;
         win_level <= iepr_pkg::IEPR_LEVEL_NONE;
      end else begin
         irq_gated <= cell_req;
         irq_level <= cell_level;
         win_valid <= next_win_valid;
         win_index <= next_win_index;
         win_level <= next_win_level;
      end
   end

   // Assertions
   sequence s_write_ready;
      aw_held && w_held && !bvalid;
   endsequence

   sequence s_read_taken;
      arvalid && arready;
   endsequence

   chk_global_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !en_first[iepr_pkg::IEPR_GLOBAL_BIT] |=> irq_gated == 9'h000)
      else $error("request passed with master gate clear");

   chk_first_gates: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> irq_gated[4:0] ==
         ($past(irq_pending[4:0] & en_first[4:0]) & {5{$past(en_first[7])}}))
      else $error("first bank gating mismatch");

   chk_second_gates: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> irq_gated[8:5] == ($past({irq_pending[8] & en_second[3],
         irq_pending[7] & en_second[6], irq_pending[6] & en_second[0],
         irq_pending[5] & en_second[2]}) & {4{$past(en_first[7])}}))
      else $error("second bank gating mismatch");

   chk_reset_values: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> en_first == 8'h00 && en_second == 8'h00 && prio_lo == 8'h00
         && prio_hi == 8'h00 && !bvalid && !rvalid)
      else $error("register not cleared by reset");

   chk_reduced_bits: assert property (@(posedge aclk) disable iff (!aresetn)
      !FULL_VARIANT |-> en_second[2] == 1'b0 && en_second[0] == 1'b0)
      else $error("reduced variant holds a missing gate");

   chk_level_form: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> irq_level[9:0] ==
         $past({prio_hi[4], prio_lo[4], prio_hi[3], prio_lo[3], prio_hi[2], prio_lo[2],
                prio_hi[1], prio_lo[1], prio_hi[0], prio_lo[0]}))
      else $error("level not formed from priority bits");

   chk_top_never_preempted: assert property (@(posedge aclk) disable iff (!aresetn)
      in_service_valid && in_service_level == iepr_pkg::IEPR_LEVEL_TOP |=> !win_valid)
      else $error("top level handler preempted");

   chk_strict_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && win_valid |->
         !$past(in_service_valid) || win_level > $past(in_service_level))
      else $error("preempted by equal or lower level");

   chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_ready |=> bvalid && !awready && !wready)
      else $error("write not answered one cycle after both parts");

   chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      s_read_taken |=> rvalid && !arready)
      else $error("read not answered one cycle after address");

   chk_unmapped_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !wr_hit |=> bvalid && bresp == iepr_pkg::IEPR_RESP_SLVERR)
      else $error("unmapped write not refused");

   chk_en_first_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb_q && aw_addr_q == iepr_pkg::IEPR_EN_FIRST_ADDR |=>
         en_first == ($past(w_byte_q) & iepr_pkg::IEPR_EN_FIRST_MASK))
      else $error("first enable write did not land");

   chk_prio_lo_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb_q && aw_addr_q == iepr_pkg::IEPR_PRIO_LO_ADDR |=>
         prio_lo == ($past(w_byte_q) & iepr_pkg::IEPR_PRIO_MASK))
      else $error("low priority write did not land");
endmodule
`default_nettype wire

/* File: inc/iepr_pkg.sv */
// Constants shared by the interrupt enable and priority register bank
package iepr_pkg;
   // Bus and source geometry
   localparam int unsigned IEPR_ADDR_W  = 12;
   localparam int unsigned IEPR_NUM_SRC = 9;
   localparam int unsigned IEPR_IDX_W   = 4;

   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] IEPR_EN_FIRST_IDX  = 8'ha8;
   localparam logic [7:0] IEPR_EN_SECOND_IDX = 8'hb1;
   localparam logic [7:0] IEPR_PRIO_HI_IDX   = 8'hb7;
   localparam logic [7:0] IEPR_PRIO_LO_IDX   = 8'hb8;
   localparam logic [11:0] IEPR_EN_FIRST_ADDR  = {2'b00, IEPR_EN_FIRST_IDX, 2'b00};
   localparam logic [11:0] IEPR_EN_SECOND_ADDR = {2'b00, IEPR_EN_SECOND_IDX, 2'b00};
   localparam logic [11:0] IEPR_PRIO_HI_ADDR   = {2'b00, IEPR_PRIO_HI_IDX, 2'b00};
   localparam logic [11:0] IEPR_PRIO_LO_ADDR   = {2'b00, IEPR_PRIO_LO_IDX, 2'b00};

   // Field positions in the first enable register
   localparam int unsigned IEPR_GLOBAL_BIT     = 7;
   localparam int unsigned IEPR_SERIAL_BIT     = 4;
   localparam int unsigned IEPR_TIMER_ONE_BIT  = 3;
   localparam int unsigned IEPR_EXT_ONE_BIT    = 2;
   localparam int unsigned IEPR_TIMER_ZERO_BIT = 1;
   localparam int unsigned IEPR_EXT_ZERO_BIT   = 0;

   // Field positions in the second enable register
   localparam int unsigned IEPR_USB_BIT    = 6;
   localparam int unsigned IEPR_CARD_BIT   = 3;
   localparam int unsigned IEPR_SPI_BIT    = 2;
   localparam int unsigned IEPR_KEYPAD_BIT = 0;

   // Source numbering, also the polling order (lower wins a tie)
   localparam int unsigned IEPR_SRC_EXT_ZERO   = 0;
   localparam int unsigned IEPR_SRC_TIMER_ZERO = 1;
   localparam int unsigned IEPR_SRC_EXT_ONE    = 2;
   localparam int unsigned IEPR_SRC_TIMER_ONE  = 3;
   localparam int unsigned IEPR_SRC_SERIAL     = 4;
   localparam int unsigned IEPR_SRC_SPI        = 5;
   localparam int unsigned IEPR_SRC_KEYPAD     = 6;
   localparam int unsigned IEPR_SRC_USB        = 7;
   localparam int unsigned IEPR_SRC_CARD       = 8;

   // Writable bit masks and values after reset
   localparam logic [7:0] IEPR_EN_FIRST_MASK   = 8'h9f;
   localparam logic [7:0] IEPR_EN_SECOND_FULL  = 8'h4d;
   localparam logic [7:0] IEPR_EN_SECOND_SMALL = 8'h48;
   localparam logic [7:0] IEPR_PRIO_MASK       = 8'h1f;
   localparam logic [7:0] IEPR_REG_RESET       = 8'h00;

   // Priority levels and bus answers
   localparam logic [1:0] IEPR_LEVEL_TOP  = 2'h3;
   localparam logic [1:0] IEPR_LEVEL_NONE = 2'h0;
   localparam logic [1:0] IEPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] IEPR_RESP_SLVERR = 2'h2;
endpackage

/* File: tb/iepr_core_model.sv */
// Behavioural processor core that enters handlers offered by the bank
`timescale 1ns/10ps
`default_nettype none
module iepr_core_model (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Arbitration result and take command
   input  wire logic       win_valid,
   input  wire logic [1:0] win_level,
   input  wire logic       take,
   // Running handler
   output logic            in_service_valid,
   output logic [1:0]      in_service_level
);
   // Enter the offered winner; a new winner nests over the running one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_service_valid <= 1'b0;
         in_service_level <= 2'h0;
      end else if (take && win_valid) begin
         in_service_valid <= 1'b1;
         in_service_level <= win_level;
      end
   end
endmodule
`default_nettype wire

/* File: tb/interrupt_enable_priority_regs_tb.sv */
// Register access, gating and arbitration checks for the enable bank
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_priority_regs_tb;
   // Addresses and answers
   localparam logic [11:0] a_en1 = iepr_pkg::IEPR_EN_FIRST_ADDR;
   localparam logic [11:0] a_en2 = iepr_pkg::IEPR_EN_SECOND_ADDR;
   localparam logic [11:0] a_hi  = iepr_pkg::IEPR_PRIO_HI_ADDR;
   localparam logic [11:0] a_lo  = iepr_pkg::IEPR_PRIO_LO_ADDR;
   localparam logic [1:0]  ok    = iepr_pkg::IEPR_RESP_OKAY;
   localparam logic [1:0]  bad   = iepr_pkg::IEPR_RESP_SLVERR;
   // Bench driven signals
   logic        aclk        = 1'b0;
   logic        aresetn     = 1'b0;
   logic [11:0] awaddr      = 12'h000;
   logic        awvalid     = 1'b0;
   logic [31:0] wdata       = 32'h0;
   logic        wvalid      = 1'b0;
   logic        bready      = 1'b1;
   logic [11:0] araddr      = 12'h000;
   logic        arvalid     = 1'b0;
   logic        rready      = 1'b1;
   logic [8:0]  irq_pending = 9'h000;
   logic        take        = 1'b0;
   // Design outputs
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, isv_level, win_level;
   logic [31:0] rdata;
   logic        isv_valid, win_valid;
   logic [8:0]  irq_gated;
   logic [17:0] irq_level;
   logic [3:0]  win_index;
   logic [8:0]  red_gated;
   int          n_errors = 0;
   int          n_tests  = 0;
   int          sb [4]   = '{6, 3, 2, 0};
   int          ss [4]   = '{7, 8, 5, 6};

   iepr_top #(.FULL_VARIANT(1'b1)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .irq_pending(irq_pending), .in_service_valid(isv_valid),
      .in_service_level(isv_level), .irq_gated(irq_gated), .irq_level(irq_level),
      .win_valid(win_valid), .win_index(win_index), .win_level(win_level)
   );

   iepr_core_model model (
      .aclk(aclk), .aresetn(aresetn), .win_valid(win_valid), .win_level(win_level),
      .take(take), .in_service_valid(isv_valid), .in_service_level(isv_level)
   );

   // Reduced variant on the same bus, only its gated requests watched
   iepr_top #(.FULL_VARIANT(1'b0)) dut_reduced (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(),
      .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(),
      .bresp(), .bvalid(), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(),
      .rdata(), .rresp(), .rvalid(), .rready(rready),
      .irq_pending(irq_pending), .in_service_valid(isv_valid),
      .in_service_level(isv_level), .irq_gated(red_gated), .irq_level(),
      .win_valid(), .win_index(), .win_level()
   );

   // Clock at 125 MHz
   initial begin
      forever #4 aclk = ~aclk;
   end

   // Verdict and end of run
   task automatic finish_test();
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Compare one value and count it
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask

   // A wait that ran out ends the run
   task automatic bound(input logic got);
      if (!got) begin
         n_errors++;
         finish_test();
      end
   endtask

   // Write one register, address and data offered together
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int   n;
      logic aw_done;
      logic w_done;
      logic got;
      aw_done = 1'b0;
      w_done  = 1'b0;
      got     = 1'b0;
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 40 && !(aw_done && w_done); n++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bound(aw_done && w_done);
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge aclk);
         got = (bvalid === 1'b1);
      end
      bound(got);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   // Read one register and compare data and answer
   task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
      int   n;
      logic got;
      got     = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge aclk);
         got = (arready === 1'b1);
      end
      arvalid <= 1'b0;
      bound(got);
      got = 1'b0;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge aclk);
         got = (rvalid === 1'b1);
      end
      bound(got);
      chk("rdata", rdata, {24'h0, ed});
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask

   // Present pending flags and let the registered outputs follow
   task automatic settle(input logic [8:0] p);
      irq_pending <= p;
      repeat (2) @(posedge aclk);
   endtask

   // Pulse the core's take command for one edge
   task automatic take_one();
      take <= 1'b1;
      @(posedge aclk);
      take <= 1'b0;
   endtask

   // Main sequence
   initial begin
      int i;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(a_en1, 8'h00, ok);
      rd(a_en2, 8'h00, ok);
      rd(a_hi, 8'h00, ok);
      rd(a_lo, 8'h00, ok);
      rd(12'h000, 8'h00, bad);
      rd(12'h2a1, 8'h00, bad);
      wr(12'h004, 8'h00, bad);
      for (i = 0; i < 5; i++) begin
         wr(a_en1, 8'h80 | 8'(1 << i), ok);
         settle(9'h1ff);
         chk("gated", {23'h0, irq_gated}, 32'(1 << i));
      end
      wr(a_en1, 8'h80, ok);
      for (i = 0; i < 4; i++) begin
         wr(a_en2, 8'(1 << sb[i]), ok);
         settle(9'h1ff);
         chk("gated", {23'h0, irq_gated}, 32'(1 << ss[i]));
      end
      wr(a_en2, 8'h4d, ok);
      rd(a_en2, 8'h4d, ok);
      chk("gated_reduced", {23'h0, red_gated}, 32'h180);
      wr(a_en1, 8'h1f, ok);
      settle(9'h1ff);
      chk("gated", {23'h0, irq_gated}, 32'h0);
      chk("win_valid", {31'h0, win_valid}, 32'h0);
      wr(a_en1, 8'h9f, ok);
      rd(a_en1, 8'h9f, ok);
      settle(9'h1ff);
      chk("gated", {23'h0, irq_gated}, 32'h1ff);
      settle(9'h000);
      chk("gated", {23'h0, irq_gated}, 32'h0);
      wr(a_hi, 8'h15, ok);
      wr(a_lo, 8'h0b, ok);
      rd(a_hi, 8'h15, ok);
      rd(a_lo, 8'h0b, ok);
      settle(9'h1ff);
      chk("level", {14'h0, irq_level}, 32'h267);
      chk("win", {25'h0, win_valid, win_index, win_level}, 32'h43);
      settle(9'h01e);
      chk("win", {25'h0, win_valid, win_index, win_level}, 32'h4a);
      settle(9'h00a);
      chk("win", {25'h0, win_valid, win_index, win_level}, 32'h45);
      // Level two handler running: level three preempts, level two does not
      settle(9'h01e);
      take_one();
      settle(9'h001);
      chk("win", {25'h0, win_valid, win_index, win_level}, 32'h43);
      settle(9'h010);
      chk("win_valid", {31'h0, win_valid}, 32'h0);
      // Top level handler running: nothing preempts
      settle(9'h001);
      take_one();
      settle(9'h1ff);
      chk("win_valid", {31'h0, win_valid}, 32'h0);
      // Mid-run reset clears every register and gate
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(a_en1, 8'h00, ok);
      rd(a_hi, 8'h00, ok);
      chk("gated", {23'h0, irq_gated}, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
